//--- src/smp_pkg.sv
package smp_pkg;
  // ----------------------------------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [13:0] IDX_FRAME_CONFIG = 14'h2F01;
  localparam logic [13:0] IDX_SCL_DIV_LOW  = 14'h2F02;
  localparam logic [13:0] IDX_SCL_DIV_HIGH = 14'h2F03;
  localparam logic [13:0] IDX_SERIAL_DATA  = 14'h2F04;
  localparam logic [13:0] IDX_SERIAL_FLAGS = 14'h2F05;
  localparam logic [13:0] IDX_IRQ_ENABLE   = 14'h2F06;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CFG_RESTART_EN_BIT = 0;
  localparam int CFG_STOP_EN_BIT    = 1;
  localparam int CFG_DATA_EN_BIT    = 2;
  localparam int CFG_START_EN_BIT   = 3;
  localparam int CFG_ENDIAN_BIT     = 4;
  localparam int FLG_ACK_BIT        = 0;
  localparam int FLG_BUSY_BIT       = 1;
  localparam int IEN_XFER_BIT       = 0;
  localparam int IEN_ILLEGAL_BIT    = 1;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic       RST_ACK     = 1'b0;
  localparam logic [3:0] ACK_SLOT    = 4'h8;
  localparam logic [1:0] LAST_QUARTER = 2'h3;

  // ----------------------------------------------------------------
  // frame sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SMP_IDLE  = 3'b000,
    SMP_START = 3'b001,
    SMP_DATA  = 3'b010,
    SMP_STOP  = 3'b011,
    SMP_DONE  = 3'b100
  } smp_state_t;
endpackage

//--- src/smp_serial_master_port.sv
// Implementation choice: register access over APB.
`timescale 1ns/10ps
// Overview of operation
// R1: scl quarter period is divider_threshold plus one clocks, from high and low bytes.
// R2: endian zero sends register bit 7 first; endian one sends bit 0 first.
// R3: writing the data byte launches the frame; byte then holds received wire data.
// R4: busy flag in flags bit 1 stays set while a frame runs.
// R5: writes to config, divider or data while busy raise illegal interrupt if enabled.
// R6: when receiving, the ack bit written by software is sent in the ack slot.
// R7: when transmitting, software writes ack one; slave ack lands in that bit.
// R8: config holds start, data, stop, restart enables and bit order select.
// R9: busy clears when the frame ends; received byte and ack then readable.
// R10: register writes attempted while busy are discarded, except writes to irq enable.
// R11: transfer interrupt per finished frame; scl held low while bus owned between frames.
// R12: sda and scl are open drain; sampled sda is the wired-and of both ends.
module smp_serial_master_port #(
  parameter int FIFO_DEPTH = 2,
  parameter int FIFO_WIDTH = 8
) (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  reset_i,
  // apb slave
  input  wire logic [15:0]           paddr_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [31:0]           pwdata_i,
  output logic                       pready_o,
  output logic [31:0]                prdata_o,
  output logic                       pslverr_o,
  // two-wire bus, open drain
  input  wire logic                  scl_i,
  output logic                       scl_o,
  output logic                       scl_oe_o,
  input  wire logic                  sda_i,
  output logic                       sda_o,
  output logic                       sda_oe_o,
  // events
  output logic                       xfer_irq_o,
  output logic                       illegal_irq_o,
  // received byte stream
  output logic [FIFO_WIDTH-1:0]      rx_data_o,
  output logic                       rx_valid_o,
  input  wire logic                  rx_ready_i
);
  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] wire_pos(input logic endian, input logic [3:0] slot);
    wire_pos = endian ? slot[2:0] : 3'(7 - slot[2:0]); // R2
  endfunction

  function automatic logic is_reg(input logic [15:0] addr, input logic [13:0] idx);
    is_reg = (addr == {idx, 2'b00});
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  smp_pkg::smp_state_t   state_reg, state_next;
  logic [7:0]            cfg_reg, cfg_next;
  logic [7:0]            thl_reg, thl_next;
  logic [7:0]            thh_reg, thh_next;
  logic [7:0]            data_reg, data_next;
  logic [5:0]            flg_rsv_reg, flg_rsv_next;
  logic                  ack_reg, ack_next;
  logic [1:0]            ien_reg, ien_next;
  logic [15:0]           div_reg, div_next;
  logic [1:0]            qtr_reg, qtr_next;
  logic [3:0]            bit_reg, bit_next;
  logic                  own_reg, own_next;
  logic                  scl_low_reg, scl_low_next;
  logic                  sda_low_reg, sda_low_next;
  logic                  xirq_reg, xirq_next;
  logic                  iirq_reg, iirq_next;
  logic [FIFO_WIDTH-1:0] mem_reg [FIFO_DEPTH];
  logic [PW-1:0]         wptr_reg, wptr_next;
  logic [PW-1:0]         rptr_reg, rptr_next;
  logic [PW:0]           cnt_reg, cnt_next;
  logic                  push, pop, fifo_ready;
  logic                  wr, busy, tick;
  logic [15:0]           th;

  assign th    = {thh_reg, thl_reg};                        // R1
  assign busy  = (state_reg != smp_pkg::SMP_IDLE);          // R4
  assign tick  = (div_reg == th);                           // R1
  assign wr    = psel_i & penable_i & pwrite_i;
  assign fifo_ready = (cnt_reg != (PW+1)'(FIFO_DEPTH));

  // ----------------------------------------------------------------
  // apb read side, zero wait states
  // ----------------------------------------------------------------
  always_comb begin
    pready_o  = 1'b1;
    pslverr_o = 1'b0;
    prdata_o  = 32'h0000_0000;
    if (is_reg(paddr_i, smp_pkg::IDX_FRAME_CONFIG)) begin
      prdata_o[7:0] = cfg_reg;
    end else if (is_reg(paddr_i, smp_pkg::IDX_SCL_DIV_LOW)) begin
      prdata_o[7:0] = thl_reg;
    end else if (is_reg(paddr_i, smp_pkg::IDX_SCL_DIV_HIGH)) begin
      prdata_o[7:0] = thh_reg;
    end else if (is_reg(paddr_i, smp_pkg::IDX_SERIAL_DATA)) begin
      prdata_o[7:0] = data_reg;                              // R9
    end else if (is_reg(paddr_i, smp_pkg::IDX_SERIAL_FLAGS)) begin
      prdata_o[7:0] = {flg_rsv_reg, busy, ack_reg};          // R4
    end else if (is_reg(paddr_i, smp_pkg::IDX_IRQ_ENABLE)) begin
      prdata_o[1:0] = ien_reg;
    end else begin
      pslverr_o = psel_i & penable_i;                        // unmapped word
    end
  end

  // ----------------------------------------------------------------
  // registers and frame sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next   = state_reg;
    cfg_next     = cfg_reg;
    thl_next     = thl_reg;
    thh_next     = thh_reg;
    data_next    = data_reg;
    flg_rsv_next = flg_rsv_reg;
    ack_next     = ack_reg;
    ien_next     = ien_reg;
    div_next     = 16'h0000;
    qtr_next     = qtr_reg;
    bit_next     = bit_reg;
    own_next     = own_reg;
    xirq_next    = 1'b0;
    iirq_next    = 1'b0;
    push         = 1'b0;
    // software writes; while busy all but irq enable are dropped, and those to config, divider or data flagged
    if (wr && is_reg(paddr_i, smp_pkg::IDX_IRQ_ENABLE)) begin
      ien_next = pwdata_i[1:0];
    end else if (wr && busy) begin
      iirq_next = ien_reg[smp_pkg::IEN_ILLEGAL_BIT] &&       // R5
                  (paddr_i[15:2] >= smp_pkg::IDX_FRAME_CONFIG) &&
                  (paddr_i[15:2] <= smp_pkg::IDX_SERIAL_DATA) && (paddr_i[1:0] == 2'b00); // R10
    end else if (wr) begin
      if (is_reg(paddr_i, smp_pkg::IDX_FRAME_CONFIG)) cfg_next = pwdata_i[7:0]; // R8
      if (is_reg(paddr_i, smp_pkg::IDX_SCL_DIV_LOW))  thl_next = pwdata_i[7:0];
      if (is_reg(paddr_i, smp_pkg::IDX_SCL_DIV_HIGH)) thh_next = pwdata_i[7:0];
      if (is_reg(paddr_i, smp_pkg::IDX_SERIAL_FLAGS)) begin
        ack_next     = pwdata_i[smp_pkg::FLG_ACK_BIT];       // R6 R7
        flg_rsv_next = pwdata_i[7:2];
      end
      if (is_reg(paddr_i, smp_pkg::IDX_SERIAL_DATA)) begin
        data_next = pwdata_i[7:0];                           // R3
        qtr_next  = 2'h0;
        bit_next  = 4'h0;
        if (cfg_reg[smp_pkg::CFG_START_EN_BIT] || cfg_reg[smp_pkg::CFG_RESTART_EN_BIT]) begin
          state_next = smp_pkg::SMP_START;
        end else if (cfg_reg[smp_pkg::CFG_DATA_EN_BIT]) begin
          state_next = smp_pkg::SMP_DATA;
        end else if (cfg_reg[smp_pkg::CFG_STOP_EN_BIT]) begin
          state_next = smp_pkg::SMP_STOP;
        end else begin
          state_next = smp_pkg::SMP_DONE;                    // empty frame just completes
        end
      end
    end
    // each element is four quarters of divider_threshold plus one clocks
    if (state_reg inside {smp_pkg::SMP_START, smp_pkg::SMP_DATA, smp_pkg::SMP_STOP}) begin
      div_next = tick ? 16'h0000 : 16'(div_reg + 16'h0001);  // R1
      if (tick) begin
        qtr_next = 2'(qtr_reg + 2'h1);
        if (qtr_reg == smp_pkg::LAST_QUARTER) begin
          case (state_reg)
            smp_pkg::SMP_START: begin
              own_next = 1'b1;
              if (cfg_reg[smp_pkg::CFG_DATA_EN_BIT]) state_next = smp_pkg::SMP_DATA;
              else if (cfg_reg[smp_pkg::CFG_STOP_EN_BIT]) state_next = smp_pkg::SMP_STOP;
              else state_next = smp_pkg::SMP_DONE;
            end
            smp_pkg::SMP_DATA: begin
              // sample at the end of the high time; line is the wired-and
              if (bit_reg == smp_pkg::ACK_SLOT) begin
                ack_next = sda_i;                            // R7 R12
                if (cfg_reg[smp_pkg::CFG_STOP_EN_BIT]) state_next = smp_pkg::SMP_STOP;
                else state_next = smp_pkg::SMP_DONE;
              end else begin
                data_next[wire_pos(cfg_reg[smp_pkg::CFG_ENDIAN_BIT], bit_reg)] = sda_i; // R2 R3
                bit_next = 4'(bit_reg + 4'h1);
              end
            end
            smp_pkg::SMP_STOP: begin
              own_next   = 1'b0;
              state_next = smp_pkg::SMP_DONE;
            end
            default: state_next = smp_pkg::SMP_DONE;
          endcase
        end
      end
    end
    // completion waits for room in the receive buffer, so no byte is lost
    if (state_reg == smp_pkg::SMP_DONE && (fifo_ready || !cfg_reg[smp_pkg::CFG_DATA_EN_BIT])) begin
      push       = cfg_reg[smp_pkg::CFG_DATA_EN_BIT];
      state_next = smp_pkg::SMP_IDLE;                        // R9
      xirq_next  = ien_reg[smp_pkg::IEN_XFER_BIT];           // R11
    end
  end

  // ----------------------------------------------------------------
  // pin drive, decoded from the next state so pins come from flops
  // ----------------------------------------------------------------
  always_comb begin
    scl_low_next = 1'b0;
    sda_low_next = 1'b0;
    case (state_next)
      smp_pkg::SMP_IDLE: scl_low_next = own_next;            // R11
      smp_pkg::SMP_DONE: begin
        scl_low_next = own_next;
        sda_low_next = own_next;                              // keep sda steady while scl falls
      end
      smp_pkg::SMP_START: begin
        scl_low_next = (qtr_next < 2'h2);
        sda_low_next = (qtr_next == 2'h3);
      end
      smp_pkg::SMP_STOP: begin
        scl_low_next = (qtr_next < 2'h2);
        sda_low_next = (qtr_next != 2'h3);
      end
      smp_pkg::SMP_DATA: begin
        scl_low_next = (qtr_next < 2'h2);
        if (bit_next == smp_pkg::ACK_SLOT) sda_low_next = !ack_next; // R6
        else sda_low_next = !data_next[wire_pos(cfg_next[smp_pkg::CFG_ENDIAN_BIT], bit_next)]; // R2
      end
      default: scl_low_next = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // receive buffer pointers
  // ----------------------------------------------------------------
  always_comb begin
    pop       = rx_valid_o & rx_ready_i;
    wptr_next = wptr_reg;
    rptr_next = rptr_reg;
    if (push) wptr_next = (wptr_reg == PW'(FIFO_DEPTH-1)) ? '0 : PW'(wptr_reg + 1'b1);
    if (pop)  rptr_next = (rptr_reg == PW'(FIFO_DEPTH-1)) ? '0 : PW'(rptr_reg + 1'b1);
    cnt_next = (PW+1)'(cnt_reg + (PW+1)'(push) - (PW+1)'(pop));
  end

  assign rx_valid_o = (cnt_reg != '0);
  assign rx_data_o  = mem_reg[rptr_reg];

  // ----------------------------------------------------------------
  // flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg   <= smp_pkg::SMP_IDLE;
      cfg_reg     <= smp_pkg::RST_BYTE;
      thl_reg     <= smp_pkg::RST_BYTE;
      thh_reg     <= smp_pkg::RST_BYTE;
      data_reg    <= smp_pkg::RST_BYTE;
      flg_rsv_reg <= 6'h00;
      ack_reg     <= smp_pkg::RST_ACK;
      ien_reg     <= 2'h0;
      div_reg     <= 16'h0000;
      qtr_reg     <= 2'h0;
      bit_reg     <= 4'h0;
      own_reg     <= 1'b0;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      xirq_reg    <= 1'b0;
      iirq_reg    <= 1'b0;
      wptr_reg    <= '0;
      rptr_reg    <= '0;
      cnt_reg     <= '0;
    end else begin
      state_reg   <= state_next;
      cfg_reg     <= cfg_next;
      thl_reg     <= thl_next;
      thh_reg     <= thh_next;
      data_reg    <= data_next;
      flg_rsv_reg <= flg_rsv_next;
      ack_reg     <= ack_next;
      ien_reg     <= ien_next;
      div_reg     <= div_next;
      qtr_reg     <= qtr_next;
      bit_reg     <= bit_next;
      own_reg     <= own_next;
      scl_low_reg <= scl_low_next;
      sda_low_reg <= sda_low_next;
      xirq_reg    <= xirq_next;
      iirq_reg    <= iirq_next;
      wptr_reg    <= wptr_next;
      rptr_reg    <= rptr_next;
      cnt_reg     <= cnt_next;
    end
  end

  // buffer storage needs no reset; only valid entries are ever read
  always_ff @(posedge clk_i) begin
    if (push) mem_reg[wptr_reg] <= data_reg;
  end

  // open drain: output level fixed low, enable carries the data
  assign scl_o         = 1'b0;                                // R12
  assign sda_o         = 1'b0;
  assign scl_oe_o      = scl_low_reg;
  assign sda_oe_o      = sda_low_reg;
  assign xfer_irq_o    = xirq_reg;
  assign illegal_irq_o = iirq_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence idle_data_write;
    !busy && wr && is_reg(paddr_i, smp_pkg::IDX_SERIAL_DATA);
  endsequence
  sequence busy_cfg_write;
    busy && wr && is_reg(paddr_i, smp_pkg::IDX_FRAME_CONFIG);
  endsequence
  frame_launch_a: assert property (idle_data_write |=> busy && data_reg == $past(pwdata_i[7:0])) // R3
    else $error("data write did not launch a frame");
  busy_flag_a: assert property (busy && state_reg != smp_pkg::SMP_DONE |=> busy) // R4
    else $error("busy flag dropped before frame end");
  illegal_write_a: assert property ((busy_cfg_write and ien_reg[smp_pkg::IEN_ILLEGAL_BIT]) |=> illegal_irq_o) // R5
    else $error("illegal write not flagged");
  write_discard_a: assert property (busy_cfg_write |=> $stable(cfg_reg)) // R10
    else $error("write while busy changed config");
  divider_step_a: assert property (busy && $changed(qtr_reg) |-> $past(div_reg) == $past(th)) // R1
    else $error("quarter advanced off divider threshold");
  ack_drive_a: assert property (state_reg == smp_pkg::SMP_DATA && bit_reg == 4'h8 |-> sda_oe_o == !ack_reg) // R6
    else $error("ack slot drive wrong");
  first_bit_a: assert property (state_reg == smp_pkg::SMP_DATA && bit_reg == 4'h0 |->
                                sda_oe_o == !(cfg_reg[4] ? data_reg[0] : data_reg[7])) // R2
    else $error("bit order wrong");
  frame_end_a: assert property ($fell(busy) |-> xfer_irq_o == ien_reg[smp_pkg::IEN_XFER_BIT]) // R11
    else $error("transfer interrupt missing");
  scl_hold_a: assert property (!busy && own_reg |-> scl_oe_o) // R11
    else $error("scl not held low between frames");
endmodule

//--- testbench/smp_slave_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// two-wire slave: counts slots from each start, drives sda low only
// ----------------------------------------------------------------
module smp_slave_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // wire levels
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_oe_o,
  // behaviour chosen by the bench
  input  wire logic       read_mode_i,
  input  wire logic       ack_low_i,
  input  wire logic [7:0] send_byte_i,
  output logic [7:0]      got_byte_o
);
  logic       scl_q;
  logic       sda_q;
  logic       armed;
  logic [3:0] slot;

  // only ever pulls low; released line floats to the pull-up
  assign sda_oe_o = armed && (read_mode_i ? (slot < 4'h8 && !send_byte_i[~slot[2:0]])
                                          : (slot == 4'h8 && ack_low_i));

  // slot tracking; the fall that ends a start does not count as a slot
  always @(posedge clk_i) begin
    scl_q <= scl_i;
    sda_q <= sda_i;
    if (reset_i) begin
      slot       <= 4'h0;
      armed      <= 1'b0;
      got_byte_o <= 8'h00;
    end else if (scl_q && scl_i && sda_q && !sda_i) begin
      slot  <= 4'h0;
      armed <= 1'b0;
    end else begin
      if (scl_q && !scl_i) begin
        if (armed) begin
          slot <= (slot == 4'h8) ? 4'h0 : slot + 4'h1;
        end
        armed <= 1'b1;
      end
      if (!scl_q && scl_i && armed && slot < 4'h8) begin
        got_byte_o <= {got_byte_o[6:0], sda_i};
      end
    end
  end
endmodule

//--- testbench/smp_serial_master_port_bench.sv
`timescale 1ns/10ps
module smp_serial_master_port_bench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk_i, reset_i, psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        scl_oe, sda_oe, slv_oe, scl_w, sda_w, read_mode, ack_low;
  logic        xfer_irq, illegal_irq, rx_valid, rx_ready, scl_lvl, sda_lvl;
  logic [7:0]  rx_data, got_byte, send_byte;
  int          error_cnt, comparisons, xfer_n, illegal_n;
  time         last_rise, scl_per;
  logic [7:0]  rx_q[$];

  // open-drain wires with pull-ups
  assign scl_w = ~scl_oe;
  assign sda_w = ~(sda_oe | slv_oe);

  smp_serial_master_port dut (
    .clk_i(clk_i), .reset_i(reset_i), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
    .scl_i(scl_w), .scl_o(scl_lvl), .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda_lvl), .sda_oe_o(sda_oe),
    .xfer_irq_o(xfer_irq), .illegal_irq_o(illegal_irq), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
    .rx_ready_i(rx_ready));

  smp_slave_model slave (
    .clk_i(clk_i), .reset_i(reset_i), .scl_i(scl_w), .sda_i(sda_w), .sda_oe_o(slv_oe),
    .read_mode_i(read_mode), .ack_low_i(ack_low), .send_byte_i(send_byte), .got_byte_o(got_byte));

  // ----------------------------------------------------------------
  // clock, monitors, watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // events and popped bytes, sampled before the edge's updates land
  always @(posedge clk_i) begin
    if (xfer_irq === 1'b1) xfer_n++;
    if (illegal_irq === 1'b1) illegal_n++;
    if (rx_valid === 1'b1 && rx_ready === 1'b1) rx_q.push_back(rx_data);
  end

  always @(posedge scl_w) begin
    scl_per = $time - last_rise;
    last_rise = $time;
  end

  // whole run is about a thousand cycles; this limit of 25000 cycles leaves wide margin
  initial begin
    #100000;
    error_cnt++;
    $display("wrong value at %0t: watchdog expired", $time);
    summarize();
  end

  // ----------------------------------------------------------------
  // tasks and expectations
  // ----------------------------------------------------------------
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev8[i] = v[7 - i];
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one apb transfer; request held until pready seen high
  task automatic apb(input logic [13:0] idx, input logic wr, input logic [7:0] wd,
                     output logic [7:0] rd, output logic err);
    @(posedge clk_i);
    paddr   <= {idx, 2'b00};
    pwrite  <= wr;
    pwdata  <= {24'h000000, wd};
    psel    <= 1'b1;
    penable <= 1'b0;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [13:0] idx, input logic [7:0] d);
    logic [7:0] r;
    logic       e;
    apb(idx, 1'b1, d, r, e);
  endtask

  task automatic rd(input logic [13:0] idx, input logic [7:0] mask, input logic [7:0] exp, input string what);
    logic [7:0] r;
    logic       e;
    apb(idx, 1'b0, 8'h00, r, e);
    check(r & mask, exp, what);
    check({7'h00, e}, 8'h00, "slave error");
  endtask

  // bounded poll of the busy flag
  task automatic wait_idle();
    logic [7:0] r;
    logic       e;
    int         n;
    n = 0;
    do begin
      apb(smp_pkg::IDX_SERIAL_FLAGS, 1'b0, 8'h00, r, e);
      n++;
    end while (r[1] !== 1'b0 && n < 2000);
    check({7'h00, r[1]}, 8'h00, "busy never cleared");
  endtask

  task automatic frame(input logic [7:0] cfg, input logic ackw, input logic [7:0] d);
    wr(smp_pkg::IDX_FRAME_CONFIG, cfg);
    wr(smp_pkg::IDX_SERIAL_FLAGS, {7'h00, ackw});
    wr(smp_pkg::IDX_SERIAL_DATA, d);
    rd(smp_pkg::IDX_SERIAL_FLAGS, 8'h02, 8'h02, "busy during frame");
    wait_idle();
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] r, a, b, c, th;
    logic       e, k;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {read_mode, ack_low, send_byte, rx_ready} = '0;
    reset_i = 1'b1;
    void'($urandom(48047));
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    // reset values and an unmapped place
    rd(smp_pkg::IDX_FRAME_CONFIG, 8'hFF, 8'h00, "config reset");
    rd(smp_pkg::IDX_SCL_DIV_LOW, 8'hFF, 8'h00, "div low reset");
    rd(smp_pkg::IDX_SCL_DIV_HIGH, 8'hFF, 8'h00, "div high reset");
    rd(smp_pkg::IDX_SERIAL_FLAGS, 8'hFF, 8'h00, "flags reset");
    apb(14'h2F07, 1'b0, 8'h00, r, e);
    check({e, r[6:0]}, 8'h80, "unmapped read");
    check({6'h00, scl_lvl, sda_lvl}, 8'h00, "open drain levels");
    wr(smp_pkg::IDX_IRQ_ENABLE, 8'h03);
    $display("test registers done");
    // divider bytes read back; a small threshold keeps frames short
    a = 8'($urandom);
    th = 8'($urandom_range(3, 1));
    wr(smp_pkg::IDX_SCL_DIV_HIGH, a);
    rd(smp_pkg::IDX_SCL_DIV_HIGH, 8'hFF, a, "div high");
    wr(smp_pkg::IDX_SCL_DIV_HIGH, 8'h00);
    wr(smp_pkg::IDX_SCL_DIV_LOW, th);
    rd(smp_pkg::IDX_SCL_DIV_LOW, 8'hFF, th, "div low");
    // start, then two written bytes in both bit orders, buffer not drained
    frame(8'h08, 1'b1, 8'h00);
    a = 8'($urandom);
    b = 8'($urandom);
    ack_low <= 1'b1;
    frame(8'h04, 1'b1, a);
    check(got_byte, a, "msb first on wire");
    check(8'(scl_per), 8'(16 * (int'(th) + 1)), "scl period");
    rd(smp_pkg::IDX_SERIAL_FLAGS, 8'h03, 8'h00, "slave acked");
    rd(smp_pkg::IDX_SERIAL_DATA, 8'hFF, a, "data after write");
    ack_low <= 1'b0;
    frame(8'h14, 1'b1, b);
    check(got_byte, rev8(b), "lsb first on wire");
    rd(smp_pkg::IDX_SERIAL_FLAGS, 8'h03, 8'h01, "slave not acked");
    rd(smp_pkg::IDX_SERIAL_DATA, 8'hFF, b, "data after lsb write");
    $display("test write frames done");
    // read frame stalls on a full buffer; refused write meanwhile
    c = 8'($urandom);
    k = 1'($urandom);
    read_mode <= 1'b1;
    send_byte <= c;
    wr(smp_pkg::IDX_FRAME_CONFIG, 8'h04);
    wr(smp_pkg::IDX_SERIAL_FLAGS, {7'h00, k});
    wr(smp_pkg::IDX_SERIAL_DATA, 8'hFF);
    repeat (400) @(posedge clk_i);
    rd(smp_pkg::IDX_SERIAL_FLAGS, 8'h02, 8'h02, "busy while buffer full");
    wr(smp_pkg::IDX_SCL_DIV_LOW, ~th);
    wr(smp_pkg::IDX_FRAME_CONFIG, 8'h1B);
    rx_ready <= 1'b1;
    wait_idle();
    read_mode <= 1'b0;
    rd(smp_pkg::IDX_SERIAL_DATA, 8'hFF, c, "received byte");
    rd(smp_pkg::IDX_SERIAL_FLAGS, 8'h03, {7'h00, k}, "ack sent by master");
    rd(smp_pkg::IDX_SCL_DIV_LOW, 8'hFF, th, "refused write kept out");
    rd(smp_pkg::IDX_FRAME_CONFIG, 8'hFF, 8'h04, "refused config kept out");
    check(8'(illegal_n), 8'h02, "illegal events");
    check(8'(rx_q.size()), 8'h03, "bytes drained");
    if (rx_q.size() == 3) begin
      check(rx_q[0], a, "first popped");
      check(rx_q[1], b, "second popped");
      check(rx_q[2], c, "third popped");
    end
    check({7'h00, rx_valid}, 8'h00, "buffer empty");
    $display("test read frame done");
    // stop releases both lines; restart keeps the bus owned
    frame(8'h02, 1'b1, 8'h00);
    check({6'h00, scl_w, sda_w}, 8'h03, "lines idle after stop");
    frame(8'h01, 1'b1, 8'h00);
    check({6'h00, scl_w, sda_w}, 8'h01, "scl held after restart");
    check(8'(xfer_n), 8'h06, "transfer events");
    wr(smp_pkg::IDX_FRAME_CONFIG, 8'h00);
    wr(smp_pkg::IDX_SERIAL_DATA, 8'h00);
    wait_idle();
    $display("test stop and restart done");
    summarize();
  end
endmodule
